// ---- tpx_map.svh ----
// register map, field positions and reset values of the remote bit exchange
// assumes a 32-bit plain register port with byte addresses
`ifndef TPX_MAP_SVH
`define TPX_MAP_SVH

`define TPX_ADDR_W 8
`define TPX_DATA_W 32
`define TPX_NBITS 16
`define TPX_FB_W 2

`define TPX_REG_CTRL 8'h00
`define TPX_REG_FB1 8'h04
`define TPX_REG_FB2 8'h08
`define TPX_REG_STATUS 8'h0C
`define TPX_REG_INPUTS 8'h10

`define TPX_CTRL_EN 0
`define TPX_CTRL_CH2 1
`define TPX_ST_CH1_OK 0
`define TPX_ST_CH2_OK 1
`define TPX_ST_CH1_KNOWN 2
`define TPX_ST_CH2_KNOWN 3

`define TPX_CTRL_RESET 1'b0
`define TPX_FB_RESET 32'h5555_5555
`define TPX_ZERO32 32'h0000_0000
`define TPX_ZERO16 16'h0000
`define TPX_ONES16 16'hFFFF

`endif

// ---- tpx_pkg.sv ----
// types shared by the remote bit exchange
// constants live in tpx_map.svh
`include "tpx_map.svh"

package tpx_pkg;

    // fallback choice of one received input
    typedef enum logic [`TPX_FB_W-1:0] {
        FB_ON,
        FB_OFF,
        FB_LATEST_ON,
        FB_LATEST_OFF
    } fallback_e;

    // one channel as seen from the link receiver
    typedef struct packed {
        logic valid;
        logic ok;
        logic [`TPX_NBITS-1:0] bits;
    } chan_rx_s;

    // remote_received_inputs of both channels
    typedef struct packed {
        logic [`TPX_NBITS-1:0] ch2;
        logic [`TPX_NBITS-1:0] ch1;
    } remote_received_inputs_s;

    // register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`TPX_ADDR_W-1:0] addr;
        logic [`TPX_DATA_W-1:0] wdata;
    } reg_req_s;

endpackage : tpx_pkg

// ---- tpx_lane.sv ----
// one channel of sixteen received inputs with per-input fallback
// assumes channel status and received words synchronous to clk
`timescale 1ns/1ps
`include "tpx_map.svh"

module tpx_lane (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic enable,
    input wire logic [`TPX_NBITS*`TPX_FB_W-1:0] remote_input_fallback_setting,
    // channel
    input wire tpx_pkg::chan_rx_s rx,
    // results
    output logic [`TPX_NBITS-1:0] inputs,
    output logic known
);

    typedef struct packed {
        logic [`TPX_NBITS-1:0] outv;
        logic [`TPX_NBITS-1:0] latest;
        logic known;
    } lane_s;

    lane_s st;
    lane_s next_st;
    tpx_pkg::fallback_e mode;

    always_comb begin
        next_st = st;
        mode = tpx_pkg::FB_OFF;
        if (enable && rx.ok && rx.valid) begin
            next_st.latest = rx.bits;
            next_st.known = 1'b1;
        end
        for (int i = 0; i < `TPX_NBITS; i++) begin
            mode = tpx_pkg::fallback_e'(remote_input_fallback_setting[i*`TPX_FB_W +: `TPX_FB_W]);
            if (!enable) begin
                next_st.outv[i] = 1'b0;
            end else if (rx.ok && rx.valid) begin
                next_st.outv[i] = rx.bits[i];
            end else if (rx.ok && st.known) begin
                next_st.outv[i] = st.latest[i];
            end else begin
                unique case (mode)
                    tpx_pkg::FB_ON: next_st.outv[i] = 1'b1;
                    tpx_pkg::FB_OFF: next_st.outv[i] = 1'b0;
                    tpx_pkg::FB_LATEST_ON: next_st.outv[i] = st.known ? st.latest[i] : 1'b1;
                    tpx_pkg::FB_LATEST_OFF: next_st.outv[i] = st.known ? st.latest[i] : 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign inputs = st.outv;
    assign known = st.known;

endmodule : tpx_lane

// ---- tpx_exchange.sv ----
// remote bit exchange: two channels of sixteen received inputs behind a register port
// assumes link receivers deliver channel words and health synchronous to clk
//
// Contract
// - channel one presents sixteen received inputs, positions 1-1 to 1-16.
// - channel two presents sixteen more, 2-1 to 2-16, only when two channels are configured.
// - inputs follow the channel only while the whole function is enabled, else they are low.
// - a failed channel forces an input set to forced-high to 1.
// - a failed channel forces an input set to forced-low to 0.
// - with a hold-last choice an input keeps its last received value while the channel is lost.
// - before any value is received, hold-last-high gives 1 and hold-last-low gives 0.
// - both channels are processed continuously and mapped independently.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`include "tpx_map.svh"

module tpx_exchange (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire tpx_pkg::reg_req_s req,
    output logic [`TPX_DATA_W-1:0] rdata,
    // channel receivers
    input wire tpx_pkg::chan_rx_s rx1,
    input wire tpx_pkg::chan_rx_s rx2,
    // remote_received_inputs
    output tpx_pkg::remote_received_inputs_s remote_received_inputs
);

    typedef struct packed {
        logic en;
        logic ch2;
        logic [`TPX_DATA_W-1:0] fb1;
        logic [`TPX_DATA_W-1:0] fb2;
        logic [`TPX_DATA_W-1:0] rdata;
    } regs_s;

    logic [1:0] rst_sync;
    logic rst_n;
    regs_s st;
    regs_s next_st;
    logic [`TPX_NBITS-1:0] ch1_in;
    logic [`TPX_NBITS-1:0] ch2_in;
    logic ch1_known;
    logic ch2_known;
    logic [`TPX_DATA_W-1:0] status;

    // reset release through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_comb begin
        status = `TPX_ZERO32;
        status[`TPX_ST_CH1_OK] = rx1.ok;
        status[`TPX_ST_CH2_OK] = rx2.ok;
        status[`TPX_ST_CH1_KNOWN] = ch1_known;
        status[`TPX_ST_CH2_KNOWN] = ch2_known;
    end

    always_comb begin
        next_st = st;
        next_st.rdata = `TPX_ZERO32;
        if (req.wr) begin
            unique case (req.addr)
                `TPX_REG_CTRL: begin
                    next_st.en = req.wdata[`TPX_CTRL_EN];
                    next_st.ch2 = req.wdata[`TPX_CTRL_CH2];
                end
                `TPX_REG_FB1: next_st.fb1 = req.wdata;
                `TPX_REG_FB2: next_st.fb2 = req.wdata;
                default: ;
            endcase
        end
        if (req.rd) begin
            unique case (req.addr)
                `TPX_REG_CTRL: begin
                    next_st.rdata[`TPX_CTRL_EN] = st.en;
                    next_st.rdata[`TPX_CTRL_CH2] = st.ch2;
                end
                `TPX_REG_FB1: next_st.rdata = st.fb1;
                `TPX_REG_FB2: next_st.rdata = st.fb2;
                `TPX_REG_STATUS: next_st.rdata = status;
                `TPX_REG_INPUTS: next_st.rdata = {ch2_in, ch1_in};
                default: next_st.rdata = `TPX_ZERO32;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st.en <= `TPX_CTRL_RESET;
            st.ch2 <= `TPX_CTRL_RESET;
            st.fb1 <= `TPX_FB_RESET;
            st.fb2 <= `TPX_FB_RESET;
            st.rdata <= `TPX_ZERO32;
        end else begin
            st <= next_st;
        end
    end

    // each channel in its own lane, no shared state
    tpx_lane u_lane1 (
        .clk(clk),
        .rst_n(rst_n),
        .enable(st.en),
        .remote_input_fallback_setting(st.fb1),
        .rx(rx1),
        .inputs(ch1_in),
        .known(ch1_known)
    );

    // second set only exists with two channels configured
    tpx_lane u_lane2 (
        .clk(clk),
        .rst_n(rst_n),
        .enable(st.en && st.ch2),
        .remote_input_fallback_setting(st.fb2),
        .rx(rx2),
        .inputs(ch2_in),
        .known(ch2_known)
    );

    assign remote_received_inputs.ch1 = ch1_in;
    assign remote_received_inputs.ch2 = ch2_in;
    assign rdata = st.rdata;

    // fallback choice of every channel one input, decoded so the checks cover all positions
    logic [`TPX_NBITS-1:0] fb1_on;
    logic [`TPX_NBITS-1:0] fb1_off;
    logic [`TPX_NBITS-1:0] fb1_hold_on;
    logic [`TPX_NBITS-1:0] fb1_hold_off;
    tpx_pkg::fallback_e fb1_mode;

    always_comb begin
        fb1_on = `TPX_ZERO16;
        fb1_off = `TPX_ZERO16;
        fb1_hold_on = `TPX_ZERO16;
        fb1_hold_off = `TPX_ZERO16;
        fb1_mode = tpx_pkg::FB_OFF;
        for (int i = 0; i < `TPX_NBITS; i++) begin
            fb1_mode = tpx_pkg::fallback_e'(st.fb1[i*`TPX_FB_W +: `TPX_FB_W]);
            fb1_on[i] = (fb1_mode == tpx_pkg::FB_ON);
            fb1_off[i] = (fb1_mode == tpx_pkg::FB_OFF);
            fb1_hold_on[i] = (fb1_mode == tpx_pkg::FB_LATEST_ON);
            fb1_hold_off[i] = (fb1_mode == tpx_pkg::FB_LATEST_OFF);
        end
    end

    property p_disabled_low;
        @(posedge clk) disable iff (!rst_n)
        !st.en |=> (ch1_in == `TPX_ZERO16) && (ch2_in == `TPX_ZERO16);
    endproperty
    a_disabled_low: assert property (p_disabled_low)
        else $error("inputs not low while function disabled");

    property p_ch2_absent;
        @(posedge clk) disable iff (!rst_n)
        !st.ch2 |=> ch2_in == `TPX_ZERO16;
    endproperty
    a_ch2_absent: assert property (p_ch2_absent)
        else $error("second channel inputs active without two channels");

    property p_forced_high;
        @(posedge clk) disable iff (!rst_n)
        (st.en && !rx1.ok) |=> (ch1_in & $past(fb1_on)) == $past(fb1_on);
    endproperty
    a_forced_high: assert property (p_forced_high)
        else $error("forced-high input not 1 on failed channel");

    property p_forced_low;
        @(posedge clk) disable iff (!rst_n)
        (st.en && !rx1.ok) |=> (ch1_in & $past(fb1_off)) == `TPX_ZERO16;
    endproperty
    a_forced_low: assert property (p_forced_low)
        else $error("forced-low input not 0 on failed channel");

    sequence s_lost_latest;
        st.en && !rx1.ok && !req.wr &&
            ((fb1_hold_on | fb1_hold_off) != `TPX_ZERO16);
    endsequence

    property p_hold_last;
        @(posedge clk) disable iff (!rst_n)
        s_lost_latest ##1 s_lost_latest |=> $stable(ch1_in & (fb1_hold_on | fb1_hold_off));
    endproperty
    a_hold_last: assert property (p_hold_last)
        else $error("held input changed while channel lost");

    property p_unknown_high;
        @(posedge clk) disable iff (!rst_n)
        (st.en && !ch1_known && !(rx1.ok && rx1.valid))
            |=> (ch1_in & $past(fb1_hold_on)) == $past(fb1_hold_on);
    endproperty
    a_unknown_high: assert property (p_unknown_high)
        else $error("hold-last-high not 1 before first value");

    property p_unknown_low;
        @(posedge clk) disable iff (!rst_n)
        (st.en && !ch1_known && !(rx1.ok && rx1.valid))
            |=> (ch1_in & $past(fb1_hold_off)) == `TPX_ZERO16;
    endproperty
    a_unknown_low: assert property (p_unknown_low)
        else $error("hold-last-low not 0 before first value");

    property p_track;
        @(posedge clk) disable iff (!rst_n)
        (st.en && rx1.ok && rx1.valid) |=> ch1_in == $past(rx1.bits);
    endproperty
    a_track: assert property (p_track)
        else $error("channel one input did not follow received word");

    sequence s_ch1_quiet;
        (st.en && rx1.ok && ch1_known && !rx1.valid)
            ##1 (st.en && rx1.ok && !rx1.valid && rx2.valid);
    endsequence

    property p_independent;
        @(posedge clk) disable iff (!rst_n)
        s_ch1_quiet |=> $stable(ch1_in);
    endproperty
    a_independent: assert property (p_independent)
        else $error("channel two traffic disturbed channel one inputs");

    property p_read_once;
        @(posedge clk) disable iff (!rst_n)
        !req.rd |=> rdata == `TPX_ZERO32;
    endproperty
    a_read_once: assert property (p_read_once)
        else $error("read data present without a read");

endmodule : tpx_exchange

// ---- tpx_peer.sv ----
// peer relay model: sends its assigned operands over one channel
// assumes the bench decides link health and when a word goes out
`timescale 1ns/1ps

module tpx_peer (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control from the bench
    input wire logic link_ok,
    input wire logic send,
    input wire logic [15:0] operands,
    // channel towards the device
    output tpx_pkg::chan_rx_s rx
);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx <= '0;
        end else begin
            rx.ok <= link_ok;
            rx.valid <= send && link_ok;
            // idle words flip every cycle so stale data never passes as fresh
            rx.bits <= (send && link_ok) ? operands : ~rx.bits;
        end
    end
endmodule : tpx_peer

// ---- tpx_exchange_tb.sv ----
// self-checking bench of the remote bit exchange with two peer models
// assumes tpx_map.svh and tpx_pkg compiled first
`timescale 1ns/1ps
`include "tpx_map.svh"

module tpx_exchange_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    tpx_pkg::reg_req_s req = '0;
    logic [31:0] rdata;
    tpx_pkg::chan_rx_s rx1;
    tpx_pkg::chan_rx_s rx2;
    tpx_pkg::remote_received_inputs_s rri;
    logic ok1 = 1'b0;
    logic ok2 = 1'b0;
    logic s1 = 1'b0;
    logic s2 = 1'b0;
    logic [15:0] op1 = 16'h0000;
    logic [15:0] op2 = 16'h0000;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    tpx_exchange dut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .rx1(rx1), .rx2(rx2),
        .remote_received_inputs(rri));
    tpx_peer peer1 (.clk(clk), .rstn(rstn), .link_ok(ok1), .send(s1), .operands(op1), .rx(rx1));
    tpx_peer peer2 (.clk(clk), .rstn(rstn), .link_ok(ok2), .send(s2), .operands(op2), .rx(rx2));

    task finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk);
        req <= '0;
    endtask : wr

    task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req <= '0;
        #1;
        check(what, rdata, exp);
    endtask : rd

    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task link(input logic a, input logic b);
        @(posedge clk);
        ok1 <= a;
        ok2 <= b;
        settle();
    endtask : link

    task send(input logic [15:0] w1, input logic [15:0] w2, input logic a, input logic b);
        @(posedge clk);
        op1 <= w1;
        op2 <= w2;
        s1 <= a;
        s2 <= b;
        @(posedge clk);
        s1 <= 1'b0;
        s2 <= 1'b0;
        settle();
    endtask : send

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        // register reset values, unmapped and read-only places
        rd("ctrl", `TPX_REG_CTRL, `TPX_ZERO32);
        rd("fb1", `TPX_REG_FB1, `TPX_FB_RESET);
        rd("fb2", `TPX_REG_FB2, `TPX_FB_RESET);
        wr(8'h14, 32'hFFFF_FFFF);
        rd("unmapped", 8'h14, `TPX_ZERO32);
        wr(`TPX_REG_STATUS, 32'h0000_000F);
        rd("status", `TPX_REG_STATUS, `TPX_ZERO32);
        $display("test registers done");
        // words arriving while the function is off
        link(1'b1, 1'b0);
        send(16'hA5C3, 16'h0000, 1'b1, 1'b0);
        check("ch1 disabled", {16'h0000, rri.ch1}, `TPX_ZERO32);
        rd("status", `TPX_REG_STATUS, 32'h0000_0001);
        $display("test disabled done");
        // channel one with one input of each fallback kind per nibble
        wr(`TPX_REG_CTRL, 32'h0000_0001);
        wr(`TPX_REG_FB1, 32'hE4E4_E4E4);
        settle();
        check("ch1 unknown", {16'h0000, rri.ch1}, 32'h0000_5555);
        link(1'b0, 1'b0);
        check("ch1 lost unknown", {16'h0000, rri.ch1}, 32'h0000_5555);
        link(1'b1, 1'b0);
        send(16'hA5C3, 16'h0000, 1'b1, 1'b0);
        check("ch1 word", {16'h0000, rri.ch1}, 32'h0000_A5C3);
        rd("inputs", `TPX_REG_INPUTS, 32'h0000_A5C3);
        link(1'b0, 1'b0);
        check("ch1 failed", {16'h0000, rri.ch1}, {16'h0000, (16'hA5C3 & 16'hCCCC) | 16'h1111});
        link(1'b1, 1'b0);
        check("ch1 restored", {16'h0000, rri.ch1}, 32'h0000_A5C3);
        send(16'h3C5A, 16'h0000, 1'b1, 1'b0);
        check("ch1 next", {16'h0000, rri.ch1}, 32'h0000_3C5A);
        $display("test channel one done");
        // channel two absent, then present and independent
        link(1'b1, 1'b1);
        send(16'h3C5A, 16'h1234, 1'b0, 1'b1);
        check("ch2 absent", {16'h0000, rri.ch2}, `TPX_ZERO32);
        wr(`TPX_REG_CTRL, 32'h0000_0003);
        wr(`TPX_REG_FB2, `TPX_ZERO32);
        link(1'b1, 1'b0);
        check("ch2 fallback", rri, {16'hFFFF, 16'h3C5A});
        link(1'b1, 1'b1);
        send(16'h0FF0, 16'hC00C, 1'b1, 1'b1);
        rd("inputs both", `TPX_REG_INPUTS, 32'hC00C_0FF0);
        rd("status both", `TPX_REG_STATUS, 32'h0000_000F);
        link(1'b0, 1'b1);
        check("ch1 lost", rri, {16'hC00C, (16'h0FF0 & 16'hCCCC) | 16'h1111});
        // peer two forwards the word that channel one can no longer carry
        send(16'h0000, 16'h0FF0, 1'b0, 1'b1);
        check("ch2 forwarded", {16'h0000, rri.ch2}, 32'h0000_0FF0);
        // same operand on matching positions of both channels survives a lost channel
        link(1'b1, 1'b1);
        send(16'h6996, 16'h6996, 1'b1, 1'b1);
        link(1'b0, 1'b1);
        check("ch2 redundant", {16'h0000, rri.ch2}, 32'h0000_6996);
        $display("test channel two done");
        // switching the function off clears both sets
        wr(`TPX_REG_CTRL, `TPX_ZERO32);
        settle();
        check("both off", rri, `TPX_ZERO32);
        $display("test disable done");
        finish_test();
    end
endmodule : tpx_exchange_tb
